// ===== common/tpc_pkg.sv
// Purpose: Shared constants for the 16-bit timer, PWM and capture block.
// Assumes: One bus clock domain; all pins sampled synchronously.
// Notes:   Field encodings and widths used by the top and channel modules.
`default_nettype none
package tpc_pkg;
    // ========================================
    // Counter
    localparam int          CNT_W       = 16;
    localparam logic [15:0] CNT_ZERO    = 16'h0000;
    localparam logic [15:0] CNT_ONE     = 16'h0001;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam int          CH_COUNT    = 2;
    // ========================================
    // Clock source field
    localparam int          CLKS_W      = 2;
    localparam logic [1:0]  CLKS_NONE   = 2'h0;
    localparam logic [1:0]  CLKS_BUS    = 2'h1;
    localparam logic [1:0]  CLKS_FIXED  = 2'h2;
    localparam logic [1:0]  CLKS_EXT    = 2'h3;
    // ========================================
    // Prescaler, divide by two to the power of the select
    localparam int          PRE_W       = 3;
    localparam int          PS_W        = 7;
    localparam logic [2:0]  PRE_MAX     = 3'h7;
    localparam logic [6:0]  PS_ONES     = 7'h7F;
    localparam logic [6:0]  PS_ZERO     = 7'h00;
    // ========================================
    // Channel modes and pin actions
    localparam int          MODE_W      = 2;
    localparam logic [1:0]  MODE_CAPT   = 2'h0;
    localparam logic [1:0]  MODE_CMP    = 2'h1;
    localparam logic [1:0]  MODE_PWM    = 2'h2;
    localparam int          ACT_W       = 2;
    localparam logic [1:0]  ACT_NONE    = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
    localparam logic [1:0]  ACT_CLEAR   = 2'h2;
    localparam logic [1:0]  ACT_SET     = 2'h3;
    localparam int          BYTE_W      = 8;
endpackage
`default_nettype wire

// ===== src/tpc_channel.sv
// Purpose: One timer channel: capture, compare or edge/center PWM.
// Assumes: Counter step and wrap pulses arrive with the new count.
// Notes:   Channel value bytes are buffered and moved as a pair outside capture mode.
`default_nettype none
module tpc_channel (
    // Clock and reset
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst_n,
    // Configuration
    input  wire logic [tpc_pkg::MODE_W-1:0]    i_mode,
    input  wire logic [tpc_pkg::ACT_W-1:0]     i_action,
    input  wire logic                          i_center,
    // Counter view
    input  wire logic [tpc_pkg::CNT_W-1:0]     i_cnt,
    input  wire logic                          i_up,
    input  wire logic                          i_step,
    input  wire logic                          i_wrap,
    // Software access
    input  wire logic                          i_val_hi_wr,
    input  wire logic                          i_val_lo_wr,
    input  wire logic [tpc_pkg::BYTE_W-1:0]    i_val_data,
    input  wire logic                          i_csc_wr,
    input  wire logic                          i_flag_clr,
    // Pin and status
    input  wire logic                          i_pin_in,
    output logic                               o_pin_out,
    output logic                               o_pin_oe_n,
    output logic                               o_flag,
    output logic [tpc_pkg::CNT_W-1:0]          o_value
);
    import tpc_pkg::*;

    // ========================================
    // State
    typedef struct packed {
        logic              cap_prev;
        logic              pin;
        logic              oe_n;
        logic              flag;
        logic              got_hi;
        logic              got_lo;
        logic [BYTE_W-1:0] buf_hi;
        logic [BYTE_W-1:0] buf_lo;
        logic [CNT_W-1:0]  val;
    } tpc_chan_s;

    tpc_chan_s s;
    tpc_chan_s next_s;
    logic      match;
    logic      pol;
    logic      set_ev;

    assign match = i_step & (i_cnt == s.val);
    assign pol   = i_action[0];

    always_comb begin
        next_s = s;
        set_ev = 1'b0;
        next_s.cap_prev = i_pin_in;
        case (i_mode)
            MODE_CAPT: begin
                next_s.oe_n = 1'b1;
                if (i_pin_in & ~s.cap_prev) begin
                    next_s.val = i_cnt;
                    set_ev = 1'b1;
                end
            end
            MODE_CMP: begin
                next_s.oe_n = (i_action == ACT_NONE);
                if (match) begin
                    set_ev = 1'b1;
                    case (i_action)
                        ACT_TOGGLE: next_s.pin = ~s.pin;
                        ACT_CLEAR:  next_s.pin = 1'b0;
                        ACT_SET:    next_s.pin = 1'b1;
                        default:    next_s.pin = s.pin;
                    endcase
                end
            end
            MODE_PWM: begin
                next_s.oe_n = 1'b0;
                if (match) begin
                    set_ev = 1'b1;
                    // Compare wins over overflow so a zero value gives a flat line.
                    next_s.pin = i_center ? (i_up ? pol : ~pol) : pol;
                end else if (i_wrap && !i_center) begin
                    next_s.pin = ~pol;
                end
            end
            default: begin
                next_s.oe_n = 1'b1;
            end
        endcase
        if (i_val_hi_wr) begin
            next_s.buf_hi = i_val_data;
            next_s.got_hi = 1'b1;
        end
        if (i_val_lo_wr) begin
            next_s.buf_lo = i_val_data;
            next_s.got_lo = 1'b1;
        end
        if (i_csc_wr) begin
            next_s.got_hi = 1'b0;
            next_s.got_lo = 1'b0;
        end
        if (next_s.got_hi && next_s.got_lo) begin
            next_s.got_hi = 1'b0;
            next_s.got_lo = 1'b0;
            if (i_mode != MODE_CAPT) begin
                next_s.val = {next_s.buf_hi, next_s.buf_lo};
            end
        end
        // A new event in the clearing cycle keeps the flag set.
        next_s.flag = (s.flag & ~i_flag_clr) | set_ev;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{oe_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign o_pin_out  = s.pin;
    assign o_pin_oe_n = s.oe_n;
    assign o_flag     = s.flag;
    assign o_value    = s.val;

    // ========================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    cmp_flag_set_a: assert property ((i_mode == MODE_CMP) && match |=> o_flag)
        else $error("compare match did not set the channel flag");
    pwm_wrap_level_a: assert property ((i_mode == MODE_PWM) && !i_center && i_wrap && !match
        |=> o_pin_out == ~$past(pol))
        else $error("edge pwm overflow drove the wrong level");
    pair_only_a: assert property (i_val_hi_wr && !i_val_lo_wr && !s.got_lo && !i_csc_wr
        && i_mode == MODE_CMP |=> $stable(o_value))
        else $error("single byte write changed the channel value");
    cap_edge_a: assert property ((i_mode == MODE_CAPT) && i_pin_in && !s.cap_prev
        |=> o_flag && o_value == $past(i_cnt))
        else $error("capture did not latch the count");
    pwm_zero_c: cover property ((i_mode == MODE_PWM) && i_wrap && match);
    pair_done_c: cover property (i_val_hi_wr ##[1:4] i_val_lo_wr);
endmodule
`default_nettype wire

// ===== src/tpc_timer.sv
// Purpose: 16-bit timer counter with clock select, modulus, overflow
//          flag and a set of capture, compare and PWM channels.
// Assumes: Control bits arrive as plain ports; write strobes are pulses.
// Notes:   Crystal and external clocks cross through two-flop stages.
`default_nettype none
// Operation
// - Two-bit source field: none, bus clock, fixed clock, external pin.
// - Bus clock source feeds the prescaler every cycle, unsynchronized.
// - Fixed clock equals bus clock unless the loop is engaged; then synchronized.
// - External clock from any channel pin always passes a two-flop synchronizer.
// - Interrupt level is overflow flag and enable, or any enabled channel flag; overflow enable low means polling.
// - Free running count wraps from 0xFFFF to 0x0000, setting overflow.
// - With a modulus, count returns to zero after it and sets overflow.
// - Center mode counts up and down; overflow on reversal at the modulus.
// - Modulus 0x0000 or 0xFFFF gives a free running full range counter.
// - Counter reads are harmless; a write to either byte clears it.
// - Counter runs up or modulo normally and up/down in center mode.
// - A capture event sets the channel flag and may request an interrupt.
// - Compare match sets, clears or toggles the pin and sets the flag.
// - Compare value moves only after both bytes; control write restarts pairing.
// - Edge PWM counts up; modulus sets period and channel value duty.
// - Polarity low: overflow drives high, compare low; polarity high reversed.
// - Value zero gives no pulse; value above modulus gives full duty.
// - Channel byte writes land in buffers and move as a pair, except in capture mode, where the pair is dropped.
// - The source field feeds the prescaler, which clocks the counter.
module tpc_timer #(
    parameter int N_CH = tpc_pkg::CH_COUNT
) (
    // Clock and reset
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_rst_n,
    // Counter configuration
    input  wire logic [tpc_pkg::CLKS_W-1:0]        i_clock_source_field,
    input  wire logic [tpc_pkg::PRE_W-1:0]         i_prescale,
    input  wire logic [tpc_pkg::CNT_W-1:0]         i_modulus_value,
    input  wire logic                              i_center_aligned_select,
    input  wire logic                              i_overflow_irq_enable,
    input  wire logic                              i_loop_engaged,
    input  wire logic                              i_xtal_half,
    input  wire logic [$clog2(N_CH)-1:0]           i_ext_pin_sel,
    // Counter access
    input  wire logic                              i_cnt_wr,
    input  wire logic                              i_overflow_flag_clr,
    // Channel configuration and access
    input  wire logic [N_CH*tpc_pkg::MODE_W-1:0]   i_ch_mode,
    input  wire logic [N_CH*tpc_pkg::ACT_W-1:0]    i_ch_action,
    input  wire logic [N_CH-1:0]                   i_ch_irq_enable,
    input  wire logic [N_CH-1:0]                   i_ch_val_hi_wr,
    input  wire logic [N_CH-1:0]                   i_ch_val_lo_wr,
    input  wire logic [tpc_pkg::BYTE_W-1:0]        i_ch_val_data,
    input  wire logic [N_CH-1:0]                   i_ch_csc_wr,
    input  wire logic [N_CH-1:0]                   i_ch_flag_clr,
    // Channel pins
    input  wire logic [N_CH-1:0]                   i_ch_pin_in,
    output logic      [N_CH-1:0]                   o_ch_pin_out,
    output logic      [N_CH-1:0]                   o_ch_pin_oe_n,
    // Status
    output logic      [tpc_pkg::CNT_W-1:0]         o_counter_value,
    output logic                                   o_overflow_flag,
    output logic      [N_CH-1:0]                   o_ch_event_flag,
    output logic      [N_CH*tpc_pkg::CNT_W-1:0]    o_ch_value,
    output logic                                   o_irq
);
    import tpc_pkg::*;

    // ========================================
    // State
    typedef struct packed {
        logic             xs1;
        logic             xs2;
        logic             xs3;
        logic             es1;
        logic             es2;
        logic             es3;
        logic [PS_W-1:0]  ps;
        logic [CNT_W-1:0] cnt;
        logic             up;
        logic             overflow_flag;
        logic             step;
        logic             wrap;
        logic             irq;
    } tpc_timer_s;

    tpc_timer_s       s;
    tpc_timer_s       next_s;
    logic             raw;
    logic             tick;
    logic             mod_active;
    logic [CNT_W-1:0] top;
    logic [PS_W-1:0]  ps_mask;
    logic [N_CH-1:0]  ch_flag;

    always_comb begin
        next_s = s;
        // Synchronizer chains; only the second and third stages are looked at.
        next_s.xs1 = i_xtal_half;
        next_s.xs2 = s.xs1;
        next_s.xs3 = s.xs2;
        next_s.es1 = i_ch_pin_in[i_ext_pin_sel];
        next_s.es2 = s.es1;
        next_s.es3 = s.es2;
        case (i_clock_source_field)
            CLKS_BUS:   raw = 1'b1;
            CLKS_FIXED: raw = i_loop_engaged ? (s.xs2 & ~s.xs3) : 1'b1;
            CLKS_EXT:   raw = s.es2 & ~s.es3;
            default:    raw = 1'b0;
        endcase
        ps_mask = PS_ONES >> (PRE_MAX - i_prescale);
        tick    = raw & ((s.ps & ps_mask) == ps_mask);
        if (raw) begin
            next_s.ps = s.ps + PS_W'(1);
        end
        mod_active = (i_modulus_value != CNT_ZERO) && (i_modulus_value != CNT_MAX);
        top = mod_active ? i_modulus_value : CNT_MAX;
        next_s.step = tick;
        next_s.wrap = 1'b0;
        if (tick) begin
            if (!i_center_aligned_select) begin
                next_s.up = 1'b1;
                if (s.cnt == top) begin
                    next_s.cnt  = CNT_ZERO;
                    next_s.wrap = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + CNT_ONE;
                end
            end else if (s.up) begin
                if (s.cnt == top) begin
                    next_s.cnt  = s.cnt - CNT_ONE;
                    next_s.up   = 1'b0;
                    next_s.wrap = 1'b1;
                end else begin
                    next_s.cnt = s.cnt + CNT_ONE;
                end
            end else begin
                if (s.cnt == CNT_ZERO) begin
                    next_s.cnt = CNT_ONE;
                    next_s.up  = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - CNT_ONE;
                end
            end
        end
        // Any counter write restarts the count and the prescaler.
        if (i_cnt_wr) begin
            next_s.cnt  = CNT_ZERO;
            next_s.up   = 1'b1;
            next_s.ps   = PS_ZERO;
            next_s.step = 1'b0;
            next_s.wrap = 1'b0;
        end
        // The overflow wins over a clear in the same cycle.
        next_s.overflow_flag = (s.overflow_flag & ~i_overflow_flag_clr) | next_s.wrap;
        // Channel flags reach the request one cycle after they set.
        next_s.irq = (next_s.overflow_flag & i_overflow_irq_enable) | (|(ch_flag & i_ch_irq_enable));
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '{up: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign o_counter_value = s.cnt;
    assign o_overflow_flag = s.overflow_flag;
    assign o_irq           = s.irq;
    assign o_ch_event_flag = ch_flag;

    // ========================================
    // Channels
    // The pin used as external clock still feeds its own channel; software keeps
    // that channel away from capture and pin driving.
    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : gen_ch
            tpc_channel u_ch (
                .i_clk_sys   (i_clk_sys),
                .i_rst_n     (i_rst_n),
                .i_mode      (i_ch_mode[g*MODE_W +: MODE_W]),
                .i_action    (i_ch_action[g*ACT_W +: ACT_W]),
                .i_center    (i_center_aligned_select),
                .i_cnt       (s.cnt),
                .i_up        (s.up),
                .i_step      (s.step),
                .i_wrap      (s.wrap),
                .i_val_hi_wr (i_ch_val_hi_wr[g]),
                .i_val_lo_wr (i_ch_val_lo_wr[g]),
                .i_val_data  (i_ch_val_data),
                .i_csc_wr    (i_ch_csc_wr[g]),
                .i_flag_clr  (i_ch_flag_clr[g]),
                .i_pin_in    (i_ch_pin_in[g]),
                .o_pin_out   (o_ch_pin_out[g]),
                .o_pin_oe_n  (o_ch_pin_oe_n[g]),
                .o_flag      (ch_flag[g]),
                .o_value     (o_ch_value[g*CNT_W +: CNT_W])
            );
        end
    endgenerate

    // ========================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    no_clock_hold_a: assert property ((i_clock_source_field == CLKS_NONE) && !i_cnt_wr
        |=> $stable(o_counter_value))
        else $error("counter moved with no clock source");
    bus_step_a: assert property ((i_clock_source_field == CLKS_BUS) && i_prescale == 3'h0
        && !i_cnt_wr && !i_center_aligned_select && o_counter_value != top
        |=> o_counter_value == $past(o_counter_value) + CNT_ONE)
        else $error("bus clock did not step the counter each cycle");
    cnt_write_a: assert property (i_cnt_wr |=> o_counter_value == CNT_ZERO)
        else $error("counter write did not clear the count");
    wrap_flag_a: assert property (tick && !i_cnt_wr && !i_center_aligned_select && s.cnt == top
        |=> o_counter_value == CNT_ZERO && o_overflow_flag)
        else $error("wrap did not clear count and set overflow");
    center_rev_a: assert property (tick && !i_cnt_wr && i_center_aligned_select && s.up
        && s.cnt == top |=> o_overflow_flag && !s.up)
        else $error("center reversal missed overflow");
    irq_level_a: assert property (o_overflow_flag && i_overflow_irq_enable && !i_overflow_flag_clr
        |=> o_irq)
        else $error("overflow with enable did not raise request");
    ext_sync_a: assert property ((i_clock_source_field == CLKS_EXT) && !i_ch_pin_in[i_ext_pin_sel]
        ##1 (i_clock_source_field == CLKS_EXT) && i_ch_pin_in[i_ext_pin_sel] |=> !raw)
        else $error("external edge bypassed the synchronizer");
    wrap_c: cover property (s.wrap && !i_center_aligned_select && mod_active);
    center_c: cover property (s.wrap && i_center_aligned_select);
    ext_tick_c: cover property ((i_clock_source_field == CLKS_EXT) && tick);
endmodule
`default_nettype wire

// ===== sim/tpc_pins_model.sv
// Purpose: Far side of the channel pins: external clock and capture pulses.
// Assumes: Every pin has a pull-down, so a released pin with no drive reads low.
// Notes:   The model changes its drive only just after a rising bus clock edge.
`default_nettype none
module tpc_pins_model (
    // Clock
    input  wire logic       i_clk_sys,
    // Design drive
    input  wire logic [1:0] i_pin_out,
    input  wire logic [1:0] i_pin_oe_n,
    // Resolved pin levels
    output logic      [1:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] drive = 2'h0;
    // ============
    // Pin resolution
    // A pin that the design releases follows the model or the pull-down.
    assign o_pin = (~i_pin_oe_n & i_pin_out) | (i_pin_oe_n & drive);
    // ============
    // Stimulus
    // Eight bus cycles a period stays well below a quarter of the bus rate.
    task automatic ext_clock(input int ch, input int n);
        repeat (n) begin
            @(posedge i_clk_sys);
            drive[ch] <= 1'b1;
            repeat (4) @(posedge i_clk_sys);
            drive[ch] <= 1'b0;
            repeat (3) @(posedge i_clk_sys);
        end
    endtask
    task automatic pulse(input int ch);
        @(posedge i_clk_sys);
        drive[ch] <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        drive[ch] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the timer, compare and PWM block.
// Assumes: Two channels; pin 1 doubles as the external clock pin.
// Notes:   The full 0xFFFF wrap is not run; it would cost 64k cycles.
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
$display("BAD %s expected %0h seen %0h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tpc_pkg::*;
    // ============
    // Signals
    logic        clk = 1'b0, rst_n = 1'b0, ctr = 1'b0, ovie = 1'b0, loop = 1'b0;
    logic        xtal = 1'b0, sel = 1'b1, cwr = 1'b0, oclr = 1'b0, ovf, irq;
    logic [1:0]  cs = 2'h0, chie = 2'h0, hwr = 2'h0, lwr = 2'h0, csc = 2'h0, fclr = 2'h0;
    logic [1:0]  pin, pout, poe, evf;
    logic [2:0]  pre = 3'h0;
    logic [3:0]  mode = 4'hF;
    logic [3:0]  act = 4'h0;
    logic [7:0]  dat = 8'h00;
    logic [15:0] modv = 16'h0000, cnt, c;
    logic [31:0] val;
    int          n_mismatch = 0, check_count = 0, k;
    tpc_timer uut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_clock_source_field(cs), .i_prescale(pre),
        .i_modulus_value(modv), .i_center_aligned_select(ctr), .i_overflow_irq_enable(ovie),
        .i_loop_engaged(loop), .i_xtal_half(xtal), .i_ext_pin_sel(sel), .i_cnt_wr(cwr),
        .i_overflow_flag_clr(oclr), .i_ch_mode(mode), .i_ch_action(act), .i_ch_irq_enable(chie),
        .i_ch_val_hi_wr(hwr), .i_ch_val_lo_wr(lwr), .i_ch_val_data(dat), .i_ch_csc_wr(csc),
        .i_ch_flag_clr(fclr), .i_ch_pin_in(pin), .o_ch_pin_out(pout), .o_ch_pin_oe_n(poe),
        .o_counter_value(cnt), .o_overflow_flag(ovf), .o_ch_event_flag(evf), .o_ch_value(val),
        .o_irq(irq));
    tpc_pins_model pins (.i_clk_sys(clk), .i_pin_out(pout), .i_pin_oe_n(poe), .o_pin(pin));
    // ============
    // Clocks, watchdog and closing
    initial begin
        forever #4 clk = ~clk;
    end
    // Halved crystal clock at one eighth of the bus rate.
    initial begin
        forever begin
            repeat (4) @(posedge clk);
            xtal <= ~xtal;
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ============
    // Helpers
    task automatic wr_byte(input int ch, input logic hi, input logic [7:0] d);
        @(posedge clk);
        hwr[ch] <= hi;
        lwr[ch] <= ~hi;
        dat <= d;
        @(posedge clk);
        hwr[ch] <= 1'b0;
        lwr[ch] <= 1'b0;
    endtask
    task automatic wait_cnt(input logic [15:0] v);
        for (k = 0; k < 300 && cnt !== v; k++) @(negedge clk);
    endtask
    task automatic rate(input logic [1:0] s, input logic [2:0] p, input logic lp, input int w, input logic [15:0] d);
        @(posedge clk);
        cs <= s;
        pre <= p;
        loop <= lp;
        repeat (10) @(negedge clk);
        c = cnt;
        repeat (w) @(negedge clk);
        `CHK("count rate", d, cnt - c)
    endtask
    task automatic pwm(input logic [15:0] v, input logic pol, input int n);
        @(posedge clk);
        act <= {1'b0, pol, 2'h0};
        wr_byte(1, 1'b1, v[15:8]);
        wr_byte(1, 1'b0, v[7:0]);
        repeat (14) @(negedge clk);
        `CHK("pwm drive", 1'b0, poe[1])
        `CHK("pwm value", v, val[31:16])
        k = 0;
        repeat (12) begin
            @(negedge clk);
            k += (pout[1] === 1'b1);
        end
        `CHK("pwm high cycles", n, k)
    endtask
    // ============
    // Scenarios
    task automatic t_count();
        `CHK("reset count", 16'h0000, cnt)
        @(posedge clk);
        modv <= 16'h0003;
        ovie <= 1'b1;
        cs <= CLKS_BUS;
        wait_cnt(16'h0003);
        @(negedge clk);
        `CHK("modulo wrap", 16'h0000, cnt)
        `CHK("overflow", 1'b1, ovf)
        `CHK("irq on", 1'b1, irq)
        @(posedge clk);
        cs <= CLKS_NONE;
        ovie <= 1'b0;
        repeat (4) @(negedge clk);
        c = cnt;
        `CHK("irq polled", 1'b0, irq)
        repeat (6) @(negedge clk);
        `CHK("no source hold", c, cnt)
        @(posedge clk);
        cwr <= 1'b1;
        oclr <= 1'b1;
        @(posedge clk);
        cwr <= 1'b0;
        oclr <= 1'b0;
        @(negedge clk);
        `CHK("count write", 16'h0000, cnt)
        $display("count test done");
    endtask
    task automatic t_center();
        @(posedge clk);
        ctr <= 1'b1;
        cs <= CLKS_BUS;
        wait_cnt(16'h0003);
        @(negedge clk);
        `CHK("center reverse", 16'h0002, cnt)
        `CHK("center overflow", 1'b1, ovf)
        repeat (2) @(negedge clk);
        `CHK("center bottom", 16'h0000, cnt)
        @(negedge clk);
        `CHK("center up", 16'h0001, cnt)
        @(posedge clk);
        ctr <= 1'b0;
        cs <= CLKS_NONE;
        modv <= 16'h0000;
        oclr <= 1'b1;
        @(posedge clk);
        oclr <= 1'b0;
        $display("center test done");
    endtask
    task automatic t_rates();
        rate(CLKS_BUS, 3'h2, 1'b0, 16, 16'h0004);
        rate(CLKS_FIXED, 3'h0, 1'b0, 8, 16'h0008);
        rate(CLKS_FIXED, 3'h0, 1'b1, 32, 16'h0004);
        rate(CLKS_BUS, 3'h0, 1'b0, 5, 16'h0005);
        rate(CLKS_EXT, 3'h0, 1'b0, 2, 16'h0000);
        c = cnt;
        pins.ext_clock(1, 6);
        repeat (6) @(negedge clk);
        `CHK("external edges", 16'h0006, cnt - c)
        $display("rate test done");
    endtask
    task automatic t_pair();
        @(posedge clk);
        cs <= CLKS_NONE;
        mode <= {2'h3, MODE_CMP};
        wr_byte(0, 1'b1, 8'h12);
        wr_byte(0, 1'b0, 8'h34);
        @(negedge clk);
        `CHK("pair", 16'h1234, val[15:0])
        wr_byte(0, 1'b1, 8'h56);
        @(posedge clk);
        csc[0] <= 1'b1;
        @(posedge clk);
        csc[0] <= 1'b0;
        wr_byte(0, 1'b0, 8'h78);
        @(negedge clk);
        `CHK("lone byte", 16'h1234, val[15:0])
        wr_byte(0, 1'b1, 8'h9A);
        @(negedge clk);
        `CHK("restarted pair", 16'h9A78, val[15:0])
        $display("pair test done");
    endtask
    task automatic t_compare();
        wr_byte(0, 1'b1, 8'h00);
        wr_byte(0, 1'b0, 8'h04);
        @(posedge clk);
        act <= {2'h0, ACT_SET};
        chie <= 2'h1;
        modv <= 16'h0009;
        cwr <= 1'b1;
        fclr <= 2'h1;
        @(posedge clk);
        cwr <= 1'b0;
        fclr <= 2'h0;
        cs <= CLKS_BUS;
        for (k = 0; k < 40 && evf[0] !== 1'b1; k++) @(negedge clk);
        `CHK("flag at match", 16'h0005, cnt)
        `CHK("pin set", 1'b1, pout[0])
        `CHK("pin driven", 1'b0, poe[0])
        @(negedge clk);
        `CHK("channel irq", 1'b1, irq)
        @(posedge clk);
        act <= {2'h0, ACT_CLEAR};
        repeat (10) @(negedge clk);
        `CHK("pin cleared", 1'b0, pout[0])
        @(posedge clk);
        act <= {2'h0, ACT_TOGGLE};
        repeat (10) @(negedge clk);
        `CHK("pin toggled", 1'b1, pout[0])
        $display("compare test done");
    endtask
    task automatic t_capture();
        @(posedge clk);
        cs <= CLKS_NONE;
        mode <= {2'h3, MODE_CAPT};
        fclr <= 2'h1;
        @(posedge clk);
        fclr <= 2'h0;
        repeat (3) @(negedge clk);
        c = cnt;
        `CHK("no event", 1'b0, irq)
        pins.pulse(0);
        repeat (3) @(negedge clk);
        `CHK("capture flag", 1'b1, evf[0])
        `CHK("captured count", c, val[15:0])
        `CHK("capture irq", 1'b1, irq)
        $display("capture test done");
    endtask
    task automatic t_pwm();
        @(posedge clk);
        chie <= 2'h0;
        mode <= {MODE_PWM, MODE_CMP};
        modv <= 16'h0005;
        cs <= CLKS_BUS;
        // The count stopped above the new modulus, so restart it inside the period.
        cwr <= 1'b1;
        @(posedge clk);
        cwr <= 1'b0;
        pwm(16'h0000, 1'b0, 0);
        pwm(16'h0006, 1'b0, 12);
        pwm(16'h0002, 1'b0, 4);
        pwm(16'h0002, 1'b1, 8);
        pwm(16'h0000, 1'b1, 12);
        $display("pwm test done");
    endtask
    // ============
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_count();
        t_center();
        t_rates();
        t_pair();
        t_compare();
        t_capture();
        t_pwm();
        end_of_test();
    end
endmodule
`default_nettype wire
